/* File: hdl/glpe_channel.sv */
// one pin's level encoder: picks the counter pair of the logical level
// and runs high then low segments counted in time base ticks
// assumes: tick comes from a glpe_timebase fed by activeTb and restart
`timescale 1ns/100ps

module glpe_channel (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin setup
  input wire logic enable,
  input wire logic level,
  input wire logic [1:0] tbSelect,
  // counter pairs for logical low and logical high
  input wire logic [6:0] lowHc,
  input wire logic [6:0] lowLc,
  input wire logic [6:0] highHc,
  input wire logic [6:0] highLc,
  // time base
  input wire logic tick,
  output logic restart,
  output logic [1:0] activeTb,
  // pin and state
  output logic pinOut,
  output glpe_pkg::glpe_phase_t phase
);

  logic running;
  logic [6:0] count;
  logic [6:0] heldLc;
  logic next_running;
  logic [6:0] next_count;
  logic [6:0] next_heldLc;
  logic [1:0] next_activeTb;
  logic next_pinOut;
  glpe_pkg::glpe_phase_t next_phase;
  logic [6:0] selHc;
  logic [6:0] selLc;
  logic cycleEnd;

  // settings are sampled only here, so a cycle never mixes settings
  always_comb begin
    selHc = level ? highHc : lowHc;
    selLc = level ? highLc : lowLc;
    cycleEnd = tick && ((phase == glpe_pkg::PH_STATIC_LOW)
                        || (phase == glpe_pkg::PH_STATIC_HIGH)
                        || (phase == glpe_pkg::PH_LOW && count == 7'h00));
    restart = enable && (!running || cycleEnd);
  end

  always_comb begin
    next_running = running;
    next_count = count;
    next_heldLc = heldLc;
    next_activeTb = activeTb;
    next_phase = phase;
    if (!enable) begin
      // pin not an output: no waveform, restart cleanly when enabled
      next_running = 1'b0;
      next_count = 7'h00;
      next_phase = glpe_pkg::PH_STATIC_LOW;
    end else if (restart) begin
      next_running = 1'b1;
      next_activeTb = tbSelect;
      next_heldLc = selLc;
      if (selHc == 7'h00) begin
        next_phase = glpe_pkg::PH_STATIC_LOW;
      end else if (selLc == 7'h00) begin
        next_phase = glpe_pkg::PH_STATIC_HIGH;
      end else begin
        next_phase = glpe_pkg::PH_HIGH;
        next_count = selHc - 7'h01;
      end
    end else if (tick) begin
      case (phase)
        glpe_pkg::PH_HIGH: begin
          if (count == 7'h00) begin
            next_phase = glpe_pkg::PH_LOW;
            next_count = heldLc - 7'h01;
          end else begin
            next_count = count - 7'h01;
          end
        end
        glpe_pkg::PH_LOW: begin
          next_count = count - 7'h01;
        end
        default: begin
          next_count = count;
        end
      endcase
    end
    next_pinOut = (next_phase == glpe_pkg::PH_HIGH)
                  || (next_phase == glpe_pkg::PH_STATIC_HIGH);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running <= 1'b0;
      count <= 7'h00;
      heldLc <= 7'h00;
      activeTb <= 2'b00;
      phase <= glpe_pkg::PH_STATIC_LOW;
      pinOut <= 1'b0;
    end else begin
      running <= next_running;
      count <= next_count;
      heldLc <= next_heldLc;
      activeTb <= next_activeTb;
      phase <= next_phase;
      pinOut <= next_pinOut;
    end
  end

endmodule : glpe_channel

/* File: hdl/glpe_encoder.sv */
// level pwm encoder for pin 2 (fault) and pin 3 (overcurrent channel a)
// with its axi4-lite register slave
// assumes: one master at a time, one write and one read in flight at most
`timescale 1ns/100ps
`include "glpe_map.svh"

module glpe_encoder (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pin 2, fault function
  output logic pin2Out,
  output logic pin2OutEn,
  // pin 3, overcurrent channel a function
  output logic overcurrentChannelAOutput,
  output logic pin3OutEn
);

  // config words, index 0..3 = pin2 low, pin2 high, pin3 low, pin3 high
  logic [15:0] cfgRegs [`GLPE_NUM_CFG];
  logic [15:0] next_cfgRegs [`GLPE_NUM_CFG];
  logic [3:0] ctrl;
  logic [3:0] next_ctrl;

  // write path state
  logic awHeld;
  logic [7:0] awIdx;
  logic wHeld;
  logic [15:0] wData;
  logic [1:0] wStrb;
  logic bValid;
  logic [1:0] bResp;
  logic next_awHeld;
  logic [7:0] next_awIdx;
  logic next_wHeld;
  logic [15:0] next_wData;
  logic [1:0] next_wStrb;
  logic next_bValid;
  logic [1:0] next_bResp;

  // read path state
  logic rValid;
  logic [31:0] rData;
  logic [1:0] rResp;
  logic next_rValid;
  logic [31:0] next_rData;
  logic [1:0] next_rResp;

  // per pin channel wires
  logic [1:0] pinOut;
  logic [1:0] tick;
  logic [1:0] restart;
  logic [1:0] activeTb [2];
  glpe_pkg::glpe_phase_t phase [2];
  logic [15:0] statusWord;

  // the four config words sit at consecutive indices
  function automatic logic is_cfg(input logic [7:0] idx);
    is_cfg = (idx >= `GLPE_IDX_PIN2_LL) && (idx <= `GLPE_IDX_PIN3_LH);
  endfunction : is_cfg

  function automatic logic [1:0] cfg_slot(input logic [7:0] idx);
    logic [7:0] offset;
    offset = idx - `GLPE_IDX_PIN2_LL;
    cfg_slot = offset[1:0];
  endfunction : cfg_slot

  function automatic logic is_mapped(input logic [7:0] idx, input logic [1:0] low);
    is_mapped = (low == 2'b00)
                && (is_cfg(idx) || idx == `GLPE_IDX_CTRL || idx == `GLPE_IDX_STATUS);
  endfunction : is_mapped

  // unaligned or foreign addresses fall outside every index: ff is no register
  function automatic logic [7:0] decode_index(input logic [11:0] addr);
    if (addr[11:10] == 2'b00 && is_mapped(addr[9:2], addr[1:0])) begin
      decode_index = addr[9:2];
    end else begin
      decode_index = 8'hff;
    end
  endfunction : decode_index

  // byte lanes 0 and 1 only; upper strobes have no storage behind them
  function automatic logic [15:0] merge_lanes(input logic [15:0] old,
                                              input logic [15:0] data,
                                              input logic [1:0] strb);
    logic [7:0] upper;
    logic [7:0] lower;
    upper = strb[1] ? data[15:8] : old[15:8];
    lower = strb[0] ? data[7:0] : old[7:0];
    merge_lanes = {upper, lower};
  endfunction : merge_lanes

  // ready is combinational from held state: aw and w are taken in either
  // order, neither again until the answer is retired; a read answers one
  // edge after it is taken

  assign s_axi_awready = !awHeld && !bValid;
  assign s_axi_wready = !wHeld && !bValid;
  assign s_axi_bvalid = bValid;
  assign s_axi_bresp = bResp;
  assign s_axi_arready = !rValid;
  assign s_axi_rvalid = rValid;
  assign s_axi_rdata = rData;
  assign s_axi_rresp = rResp;

  // write path and register file
  always_comb begin
    logic [1:0] slot;
    slot = cfg_slot(awIdx);
    next_awHeld = awHeld;
    next_awIdx = awIdx;
    next_wHeld = wHeld;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bValid = bValid;
    next_bResp = bResp;
    next_ctrl = ctrl;
    for (int i = 0; i < `GLPE_NUM_CFG; i++) begin
      next_cfgRegs[i] = cfgRegs[i];
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awIdx = decode_index(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata[15:0];
      next_wStrb = s_axi_wstrb[1:0];
    end
    if (awHeld && wHeld) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValid = 1'b1;
      next_bResp = `GLPE_RESP_OKAY;
      if (is_cfg(awIdx)) begin
        // reserved top bits of the high-level words stay zero
        next_cfgRegs[slot] = merge_lanes(cfgRegs[slot], wData, wStrb)
                             & (slot[0] ? `GLPE_LH_WMASK : 16'hffff);
      end else if (awIdx == `GLPE_IDX_CTRL) begin
        next_ctrl = wStrb[0] ? wData[3:0] : ctrl;
      end else if (awIdx != `GLPE_IDX_STATUS) begin
        next_bResp = `GLPE_RESP_SLVERR;
      end
    end else if (bValid && s_axi_bready) begin
      next_bValid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      awIdx <= 8'h00;
      wHeld <= 1'b0;
      wData <= 16'h0000;
      wStrb <= 2'b00;
      bValid <= 1'b0;
      bResp <= `GLPE_RESP_OKAY;
      ctrl <= `GLPE_RST_CTRL;
      for (int i = 0; i < `GLPE_NUM_CFG; i++) begin
        cfgRegs[i] <= (i % 2 == 0) ? `GLPE_RST_LL : `GLPE_RST_LH;
      end
    end else begin
      awHeld <= next_awHeld;
      awIdx <= next_awIdx;
      wHeld <= next_wHeld;
      wData <= next_wData;
      wStrb <= next_wStrb;
      bValid <= next_bValid;
      bResp <= next_bResp;
      ctrl <= next_ctrl;
      for (int i = 0; i < `GLPE_NUM_CFG; i++) begin
        cfgRegs[i] <= next_cfgRegs[i];
      end
    end
  end

  // status shows the live pin levels and encoder phases
  assign statusWord = {10'h000,
                       phase[1],
                       phase[0],
                       pinOut};

  // read path
  always_comb begin
    logic [7:0] idx;
    logic [1:0] slot;
    idx = decode_index(s_axi_araddr);
    slot = cfg_slot(idx);
    next_rValid = rValid;
    next_rData = rData;
    next_rResp = rResp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rValid = 1'b1;
      next_rResp = `GLPE_RESP_OKAY;
      next_rData = 32'h0000_0000;
      if (idx == 8'hff) begin
        // unmapped reads answer an error with zero data
        next_rResp = `GLPE_RESP_SLVERR;
      end else begin
        case (idx)
          `GLPE_IDX_CTRL: begin
            next_rData = {28'h000_0000, ctrl};
          end
          `GLPE_IDX_STATUS: begin
            next_rData = {16'h0000, statusWord};
          end
          default: begin
            next_rData = {16'h0000, cfgRegs[slot]};
          end
        endcase
      end
    end else if (rValid && s_axi_rready) begin
      next_rValid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rValid <= 1'b0;
      rData <= 32'h0000_0000;
      rResp <= `GLPE_RESP_OKAY;
    end else begin
      rValid <= next_rValid;
      rData <= next_rData;
      rResp <= next_rResp;
    end
  end

  // one time base and one encoder per pin; the time base select lives
  // in the low-level word of each pin
  for (genvar p = 0; p < 2; p++) begin : g_pin
    logic [15:0] lowWord;
    logic [15:0] highWord;
    assign lowWord = cfgRegs[2 * p];
    assign highWord = cfgRegs[2 * p + 1];

    glpe_timebase u_timebase (
      .clk(clk),
      .rst_n(rst_n),
      .clear(restart[p]),
      .tbSelect(activeTb[p]),
      .tick(tick[p])
    );

    glpe_channel u_channel (
      .clk(clk),
      .rst_n(rst_n),
      .enable(ctrl[2 * p + `GLPE_CTRL_EN]),
      .level(ctrl[2 * p + `GLPE_CTRL_LEVEL]),
      .tbSelect(lowWord[`GLPE_TB_MSB:`GLPE_TB_LSB]),
      .lowHc(glpe_pkg::cfg_high_count(lowWord)),
      .lowLc(glpe_pkg::cfg_low_count(lowWord)),
      .highHc(glpe_pkg::cfg_high_count(highWord)),
      .highLc(glpe_pkg::cfg_low_count(highWord)),
      .tick(tick[p]),
      .restart(restart[p]),
      .activeTb(activeTb[p]),
      .pinOut(pinOut[p]),
      .phase(phase[p])
    );
  end

  // an enabled pin drives at once; its waveform starts at the first boundary
  assign pin2Out = pinOut[0];
  assign overcurrentChannelAOutput = pinOut[1];
  assign pin2OutEn = ctrl[`GLPE_CTRL_EN];
  assign pin3OutEn = ctrl[2 + `GLPE_CTRL_EN];

endmodule : glpe_encoder

/* File: hdl/glpe_map.svh */
// register indices, field positions, reset values and divider counts
// assumes: included by the package and by every design file that needs a figure
`ifndef GLPE_MAP_SVH
`define GLPE_MAP_SVH

// register indices; byte address is four times the index
`define GLPE_IDX_PIN2_LL 8'h53
`define GLPE_IDX_PIN2_LH 8'h54
`define GLPE_IDX_PIN3_LL 8'h55
`define GLPE_IDX_PIN3_LH 8'h56
`define GLPE_IDX_CTRL 8'h60
`define GLPE_IDX_STATUS 8'h61
`define GLPE_NUM_CFG 4

// config word fields
`define GLPE_TB_MSB 15
`define GLPE_TB_LSB 14
`define GLPE_HC_MSB 13
`define GLPE_HC_LSB 7
`define GLPE_LC_MSB 6
`define GLPE_LC_LSB 0
`define GLPE_LH_WMASK 16'h3fff

// reset values
`define GLPE_RST_LL 16'h007f
`define GLPE_RST_LH 16'h3f80
`define GLPE_RST_CTRL 4'h0

// control register bits, per pin: enable at 2*p, logical level at 2*p+1
`define GLPE_CTRL_EN 0
`define GLPE_CTRL_LEVEL 1

// time base terminal counts: 15, 63, 255, 1023, for periods of 16, 64, 256, 1024 master clocks
`define GLPE_TB_TERM_16 10'h00f
`define GLPE_TB_TERM_64 10'h03f
`define GLPE_TB_TERM_256 10'h0ff
`define GLPE_TB_TERM_1024 10'h3ff

// bus answers
`define GLPE_RESP_OKAY 2'b00
`define GLPE_RESP_SLVERR 2'b10

`endif

/* File: hdl/glpe_pkg.sv */
// types and shared arithmetic of the level pwm encoder
// assumes: glpe_map.svh sits in the include path
`include "glpe_map.svh"

package glpe_pkg;

  typedef enum logic [1:0] {
    PH_STATIC_LOW = 2'b00,
    PH_STATIC_HIGH = 2'b01,
    PH_HIGH = 2'b10,
    PH_LOW = 2'b11
  } glpe_phase_t;

  function automatic logic [9:0] tb_terminal(input logic [1:0] sel);
    case (sel)
      2'b00: tb_terminal = `GLPE_TB_TERM_16;
      2'b01: tb_terminal = `GLPE_TB_TERM_64;
      2'b10: tb_terminal = `GLPE_TB_TERM_256;
      default: tb_terminal = `GLPE_TB_TERM_1024;
    endcase
  endfunction : tb_terminal

  function automatic logic [6:0] cfg_high_count(input logic [15:0] cfg);
    cfg_high_count = cfg[`GLPE_HC_MSB:`GLPE_HC_LSB];
  endfunction : cfg_high_count

  function automatic logic [6:0] cfg_low_count(input logic [15:0] cfg);
    cfg_low_count = cfg[`GLPE_LC_MSB:`GLPE_LC_LSB];
  endfunction : cfg_low_count

endpackage : glpe_pkg

/* File: hdl/glpe_timebase.sv */
// time base divider: one-cycle tick every 16/64/256/1024 clocks
// assumes: clear comes from the channel at each cycle boundary
`timescale 1ns/100ps

module glpe_timebase (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic [1:0] tbSelect,
  // enable pulse
  output logic tick
);

  logic [9:0] count;
  logic [9:0] next_count;
  logic next_tick;
  logic [9:0] term;

  always_comb begin
    term = glpe_pkg::tb_terminal(tbSelect);
    next_tick = 1'b0;
    // clear loads one so the first segment after a boundary is a full base
    if (clear) begin
      next_count = 10'h001;
    end else if (count >= term) begin
      next_count = 10'h000;
      next_tick = 1'b1;
    end else begin
      next_count = count + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 10'h000;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule : glpe_timebase

/* File: tb/glpe_encoder_asserts.sv */
// checker on the top ports of the level pwm encoder
// assumes: bound to glpe_encoder, one clock domain
`timescale 1ns/100ps

module glpe_encoder_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic pin2Out,
  input wire logic pin2OutEn,
  input wire logic overcurrentChannelAOutput,
  input wire logic pin3OutEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // run length mod 16; first run after enable is partial, so skipped
  logic [3:0] runCnt, next_runCnt;
  logic runSeen, next_runSeen, prevPin;
  always_comb begin
    next_runCnt = (!pin2OutEn || pin2Out != prevPin) ? 4'h1 : runCnt + 4'h1;
    next_runSeen = pin2OutEn && (runSeen || pin2Out != prevPin);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      runCnt <= 4'h0;
      runSeen <= 1'b0;
      prevPin <= 1'b0;
    end else begin
      runCnt <= next_runCnt;
      runSeen <= next_runSeen;
      prevPin <= pin2Out;
    end
  end

  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  property p_wresp;
    s_wtake |=> s_answer;
  endproperty
  a_wresp: assert property (p_wresp) else $error("write answer late");
  property p_bdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bdone: assert property (p_bdone) else $error("write answer not retired");
  property p_rresp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rresp: assert property (p_rresp) else $error("read answer late");
  property p_rdone;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rdone: assert property (p_rdone) else $error("read answer not retired");
  property p_wblock;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wblock: assert property (p_wblock) else $error("write taken while answer pending");
  property p_off2;
    !pin2OutEn ##1 !pin2OutEn |-> !pin2Out;
  endproperty
  a_off2: assert property (p_off2) else $error("pin 2 driven while off");
  property p_off3;
    !pin3OutEn ##1 !pin3OutEn |-> !overcurrentChannelAOutput;
  endproperty
  a_off3: assert property (p_off3) else $error("pin 3 driven while off");
  property p_run2;
    runSeen && pin2OutEn && pin2Out != prevPin |-> runCnt == 4'h0;
  endproperty
  a_run2: assert property (p_run2) else $error("pin 2 run off time base");
endmodule : glpe_encoder_checker

bind glpe_encoder glpe_encoder_checker i_chk (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .pin2Out, .pin2OutEn,
  .overcurrentChannelAOutput, .pin3OutEn);

/* File: tb/glpe_encoder_tb.sv */
// self-checking bench: registers over axi4-lite, pin timing via observers
// assumes: glpe_pkg and the design files compiled first
`timescale 1ns/100ps

module glpe_encoder_tb;
  logic clk, rst_n;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic pin2Out, pin2OutEn, overcurrentChannelAOutput, pin3OutEn;
  int fails, numChecks, high2, low2, high3, low3, i, n;
  logic [7:0] rIdx[5] = '{8'h53, 8'h54, 8'h55, 8'h56, 8'h60};
  logic [31:0] rVal[5] = '{32'h7f, 32'h3f80, 32'h7f, 32'h3f80, 32'h0};
  logic [7:0] sIdx[4] = '{8'h54, 8'h54, 8'h54, 8'h53};
  logic [31:0] sVal[4] = '{32'h3f80, 32'h0, 32'h80, 32'h7f};
  logic [31:0] sCtl[4] = '{32'h3, 32'h3, 32'h3, 32'h1};
  logic sPin[4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  glpe_encoder i_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin2Out,
    .pin2OutEn, .overcurrentChannelAOutput, .pin3OutEn);
  glpe_pin_observer i_obs2 (.clk, .rst_n, .pin(pin2Out), .pinEn(pin2OutEn),
    .highLen(high2), .lowLen(low2));
  glpe_pin_observer i_obs3 (.clk, .rst_n, .pin(overcurrentChannelAOutput),
    .pinEn(pin3OutEn), .highLen(high3), .lowLen(low3));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task conclude;
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // a bus wait that ran out
  task stall;
    fails++;
    conclude();
  endtask : stall

  task wr(input logic [7:0] idx, input logic [31:0] d);
    int k;
    logic awDone, wDone, bDone;
    @(posedge clk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      // handshakes read mid-cycle, where they stand for the coming edge
      @(negedge clk);
      awDone = s_axi_awvalid && s_axi_awready;
      wDone = s_axi_wvalid && s_axi_wready;
      bDone = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (awDone) s_axi_awvalid <= 1'b0;
      if (wDone) s_axi_wvalid <= 1'b0;
      if (bDone) break;
    end
    s_axi_bready <= 1'b0;
    if (k == 50) stall();
  endtask : wr

  task rd(input logic [7:0] idx);
    int k;
    logic arDone, rDone;
    @(posedge clk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(negedge clk);
      arDone = s_axi_arvalid && s_axi_arready;
      rDone = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (arDone) s_axi_arvalid <= 1'b0;
      if (rDone) break;
    end
    s_axi_rready <= 1'b0;
    if (k == 50) stall();
  endtask : rd

  initial begin
    rst_n = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rd(rIdx[i]);
      chk("reset value", rdat, rVal[i]);
    end
    rd(8'h7f);
    chk("unmapped resp", resp, 32'h2);
    wr(8'h7f, 32'h0);
    chk("unmapped write resp", resp, 32'h2);
    wr(8'h54, 32'hffff);
    rd(8'h54);
    chk("reserved bits", rdat, 32'h3fff);
    // static levels, both logical levels of pin 2
    for (i = 0; i < 4; i++) begin
      wr(sIdx[i], sVal[i]);
      wr(8'h60, sCtl[i]);
      repeat (100) @(posedge clk);
      chk("static level", pin2Out, sPin[i]);
    end
    // every time base code, high one unit, low two units
    for (i = 0; i < 4; i++) begin
      n = 16 << (2 * i);
      wr(8'h53, {16'h0, i[1:0], 7'h01, 7'h02});
      repeat (12 * n + 40) @(posedge clk);
      chk("high time", high2, n);
      chk("low time", low2, 2 * n);
    end
    // pin 3 with its own pair, pin 2 switched off
    wr(8'h55, 32'h4181);
    wr(8'h60, 32'h4);
    repeat (1100) @(posedge clk);
    chk("pin 3 high time", high3, 32'd192);
    chk("pin 3 low time", low3, 32'd64);
    chk("pin 2 off", {pin2OutEn, pin2Out}, 32'h0);
    // pin 3 logical high takes its high-level word, static high from reset
    wr(8'h60, 32'hc);
    repeat (300) @(posedge clk);
    chk("pin 3 level high", overcurrentChannelAOutput, 32'h1);
    chk("pin 3 enable", pin3OutEn, 32'h1);
    rd(8'h61);
    chk("status", rdat, 32'h12);
    conclude();
  end
endmodule : glpe_encoder_tb

/* File: tb/glpe_pin_observer.sv */
// receiver on one encoded pin: last complete high and low run in clocks
// assumes: pin is a register output of the same clock
`timescale 1ns/100ps

module glpe_pin_observer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // observed pin
  input wire logic pin,
  input wire logic pinEn,
  // run lengths
  output int highLen,
  output int lowLen
);
  int cnt;
  logic last;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt = 0;
      last = 1'b0;
      highLen = 0;
      lowLen = 0;
    end else if (!pinEn) begin
      cnt = 0;
      last = pin;
    end else if (pin !== last) begin
      if (last) highLen = cnt;
      else lowLen = cnt;
      cnt = 1;
      last = pin;
    end else begin
      cnt++;
    end
  end
endmodule : glpe_pin_observer
